// file: core/tsf_mac_end.sv
/*
  MAC end of the segmented transmit bus: qualifies markers by valid, tracks
  packet framing in segment order, substitutes the error control word on an
  aborted end transfer and suppresses FCS checking for all packets ending in that cycle.
  Every output is a flip-flop and shows the bus cycle of the edge before:
    out_valid_o, out_first_o, out_last_o and out_aborted_o are per-segment
    copies of the qualified markers;
    out_word_o reads zero on an idle segment and the error word on an
    aborted end;
    out_empty_o reads zero except on an end transfer, and on an aborted
    end its low bits read zero;
    fcs_check_en_o is low for one cycle after an aborted end;
    fcs_result_valid_o pulses after a cycle with an end and no aborted end;
    framing_error_o pulses after a start inside a packet or a word outside;
    tx_accept follows path_ready_i one edge late.
  Assumes the user end keeps marker placement rules and shares mclk_i.
  Assumes the user end stops issuing as soon as it samples tx_accept low,
  since nothing here buffers words that arrive while the path is stalled.
*/
`timescale 1ns/100ps
`default_nettype none
module tsf_mac_end
  import tsf_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Segmented bus
  tsf_if.mac bus,
  // Flow control from the transmit path
  input wire logic path_ready_i,
  // Framed output per segment
  output logic [SEGS-1:0] out_valid_o,
  output logic [SEGS-1:0] out_first_o,
  output logic [SEGS-1:0] out_last_o,
  output logic [SEGS-1:0] out_aborted_o,
  output tsf_pkg::tsf_word_type out_word_o [SEGS],
  output tsf_pkg::tsf_empty_type out_empty_o [SEGS],
  // FCS control and framing status
  output logic fcs_check_en_o,
  output logic fcs_result_valid_o,
  output logic framing_error_o
);
  import tsf_pkg::*;

  // ==========================================================
  // Selection helpers
  // ==========================================================
  // Word passed downstream for one segment; idle lanes read as zero.
  function automatic tsf_word_type seg_word(
    input logic valid,
    input logic abort,
    input tsf_word_type word
  );
    tsf_word_type sel;
    sel = word;
    if (!valid) begin
      sel = WORD_RST;
    end else if (abort) begin
      sel = ERR_WORD;
    end
    return sel;
  endfunction

  // Empty count of one segment; only an end transfer carries one.
  function automatic tsf_empty_type seg_empty(
    input logic last,
    input logic abort,
    input tsf_empty_type empty
  );
    tsf_empty_type sel;
    sel = empty;
    if (!last) begin
      sel = EMPTY_RST;
    end else if (abort) begin
      sel = {empty[EMPTY_W-1:EMPTY_LOW_W], EMPTY_LOW_ZERO};
    end
    return sel;
  endfunction

  // ==========================================================
  // Segment qualification
  // ==========================================================
  tsf_seg_type first_q, last_q, abort_q;
  tsf_word_type word_nxt [SEGS];
  tsf_empty_type empty_nxt [SEGS];
  // Gating every marker by valid keeps idle-segment garbage out of framing.
  assign first_q = bus.tx_segment_first & bus.tx_segment_valid;
  assign last_q = bus.tx_segment_last & bus.tx_segment_valid;
  assign abort_q = bus.tx_segment_abort & last_q;

  genvar g;
  generate
    for (g = 0; g < SEGS; g++) begin : g_seg
      assign word_nxt[g] = seg_word(bus.tx_segment_valid[g], abort_q[g],
                                    bus.tx_segment_word[g]);
      assign empty_nxt[g] = seg_empty(last_q[g], abort_q[g],
                                      bus.tx_empty_bytes[g]);
    end
  endgenerate

  // ==========================================================
  // Packet tracking across segments
  // ==========================================================
  // Walk segments upward so a packet may end and restart in one cycle.
  tsf_state_type state_r, state_nxt;
  logic err_nxt;
  logic any_last;
  logic any_abort_end;
  always_comb begin
    logic in_pkt;
    in_pkt = (state_r == TSF_PKT);
    err_nxt = 1'b0;
    for (int i = 0; i < SEGS; i++) begin
      if (bus.tx_segment_valid[i]) begin
        if (first_q[i] == in_pkt) begin
          err_nxt = 1'b1;
        end
        in_pkt = !last_q[i];
      end
    end
    state_nxt = in_pkt ? TSF_PKT : TSF_IDLE;
  end
  assign any_last = |last_q;
  assign any_abort_end = |abort_q;

  // ==========================================================
  // Framing state
  // ==========================================================
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= TSF_IDLE;
      framing_error_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      framing_error_o <= err_nxt;
    end
  end

  // ==========================================================
  // Per-segment outputs
  // ==========================================================
  // Idle segments still register, so downstream must qualify by valid.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= '0;
      out_first_o <= '0;
      out_last_o <= '0;
      out_aborted_o <= '0;
    end else begin
      out_valid_o <= bus.tx_segment_valid;
      out_first_o <= first_q;
      out_last_o <= last_q;
      out_aborted_o <= abort_q;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_word_o <= '{default: WORD_RST};
      out_empty_o <= '{default: EMPTY_RST};
    end else begin
      out_word_o <= word_nxt;
      out_empty_o <= empty_nxt;
    end
  end

  // ==========================================================
  // FCS control
  // ==========================================================
  // A one-cycle drop suffices because checking acts on ended packets only.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fcs_check_en_o <= 1'b0;
      fcs_result_valid_o <= 1'b0;
    end else begin
      // Check is reported once per cycle with an end; an aborted end in that cycle skips it.
      fcs_result_valid_o <= any_last & !any_abort_end;
      fcs_check_en_o <= !any_abort_end;
    end
  end

  // ==========================================================
  // Flow control
  // ==========================================================
  // Registering ready costs one edge of stall latency at the user end.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bus.tx_accept <= 1'b0;
    end else begin
      bus.tx_accept <= path_ready_i;
    end
  end
endmodule
`default_nettype wire

// file: shared/tsf_pkg.sv
/*
  Package for the segmented transmit framing block: segment count, widths,
  error control word and state encodings shared by both ends.
  Assumes a single transmit clock for both ends.
*/
`default_nettype none
package tsf_pkg;
  localparam int SEGS = 4;
  localparam int WORD_W = 128;
  localparam int EMPTY_W = 4;
  // Low empty-byte bits forced to zero on an aborted end transfer.
  localparam int EMPTY_LOW_W = 3;
  localparam logic [EMPTY_LOW_W-1:0] EMPTY_LOW_ZERO = 3'h0;
  // Error control word pattern (all lanes carry the error code 0xFE).
  localparam logic [WORD_W-1:0] ERR_WORD =
    128'hFEFE_FEFE_FEFE_FEFE_FEFE_FEFE_FEFE_FEFE;
  localparam logic [EMPTY_W-1:0] EMPTY_RST = 4'h0;
  localparam logic [WORD_W-1:0] WORD_RST =
    128'h0000_0000_0000_0000_0000_0000_0000_0000;
  typedef logic [SEGS-1:0] tsf_seg_type;
  typedef logic [WORD_W-1:0] tsf_word_type;
  typedef logic [EMPTY_W-1:0] tsf_empty_type;
  typedef enum logic [1:0] {
    TSF_IDLE = 2'b01,
    TSF_PKT = 2'b10
  } tsf_state_type;
endpackage
`default_nettype wire

// file: shared/tsf_if.sv
/*
  Interface joining the user packet source and the MAC transmit framing end.
  Assumes both ends share mclk_i.
*/
`timescale 1ns/100ps
`default_nettype none
interface tsf_if;
  import tsf_pkg::*;
  tsf_seg_type tx_segment_valid;
  tsf_seg_type tx_segment_first;
  tsf_seg_type tx_segment_last;
  tsf_seg_type tx_segment_abort;
  tsf_word_type tx_segment_word [SEGS];
  tsf_empty_type tx_empty_bytes [SEGS];
  logic tx_accept;
  modport mac (
    input tx_segment_valid, tx_segment_first, tx_segment_last,
    input tx_segment_abort, tx_segment_word, tx_empty_bytes,
    output tx_accept
  );
  modport user (
    output tx_segment_valid, tx_segment_first, tx_segment_last,
    output tx_segment_abort, tx_segment_word, tx_empty_bytes,
    input tx_accept
  );
endinterface
`default_nettype wire

// file: core/tsf_user_end.sv
/*
  User end of the segmented transmit bus: sends one packet of a requested
  length in words, packing segments upward, marking first, last and abort.
  Assumes the MAC end shares mclk_i; tx_accept comes from its flip-flop.
*/
`timescale 1ns/100ps
`default_nettype none
module tsf_user_end
  import tsf_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Packet request
  input wire logic send_i,
  input wire logic [7:0] send_words_i,
  input wire logic send_abort_i,
  input wire tsf_pkg::tsf_word_type send_word_i,
  input wire tsf_pkg::tsf_empty_type send_empty_i,
  // Status
  output logic busy_o,
  // Segmented bus
  tsf_if.user bus
);
  import tsf_pkg::*;

  // ==========================================================
  // Packet sequencing
  // ==========================================================
  tsf_state_type state_r;
  logic [7:0] left_r, sent_r;
  logic abort_r;
  tsf_word_type word_r;
  tsf_empty_type empty_r;
  logic [7:0] take;
  // Stopping on the first edge that samples accept low, one edge after it drops, meets the bounded-stop duty.
  assign take = (left_r > 8'(SEGS)) ? 8'(SEGS) : left_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= TSF_IDLE;
      left_r <= '0;
      sent_r <= '0;
      abort_r <= 1'b0;
      word_r <= WORD_RST;
      empty_r <= EMPTY_RST;
      busy_o <= 1'b0;
      bus.tx_segment_valid <= '0;
      bus.tx_segment_first <= '0;
      bus.tx_segment_last <= '0;
      bus.tx_segment_abort <= '0;
      bus.tx_segment_word <= '{default: WORD_RST};
      bus.tx_empty_bytes <= '{default: EMPTY_RST};
    end else begin
      bus.tx_segment_valid <= '0;
      bus.tx_segment_first <= '0;
      bus.tx_segment_last <= '0;
      bus.tx_segment_abort <= '0;
      if (state_r == TSF_IDLE) begin
        if (send_i && send_words_i != 8'h00) begin
          state_r <= TSF_PKT;
          left_r <= send_words_i;
          sent_r <= '0;
          abort_r <= send_abort_i;
          word_r <= send_word_i;
          empty_r <= send_empty_i;
          busy_o <= 1'b1;
        end
      end else if (bus.tx_accept) begin
        for (int i = 0; i < SEGS; i++) begin
          if (8'(i) < take) begin
            bus.tx_segment_valid[i] <= 1'b1;
            bus.tx_segment_first[i] <= (sent_r == 8'h00 && i == 0);
            bus.tx_segment_last[i] <= (8'(i + 1) == left_r);
            bus.tx_segment_abort[i] <= abort_r &&
                                       8'(i + 1) == left_r;
            bus.tx_segment_word[i] <= word_r;
            bus.tx_empty_bytes[i] <= (8'(i + 1) == left_r) ?
                                     empty_r : EMPTY_RST;
          end
        end
        left_r <= left_r - take;
        sent_r <= sent_r + take;
        if (left_r == take) begin
          state_r <= TSF_IDLE;
          busy_o <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tsf_frame_monitor.sv
/*
  Checker of the wire between the user end and the MAC end.
  Assumes one clock and the interface signals wired in as plain inputs.
*/
`timescale 1ns/100ps
`default_nettype none
module tsf_frame_monitor
  import tsf_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Watched bus signals
  input wire tsf_pkg::tsf_seg_type tx_segment_valid,
  input wire tsf_pkg::tsf_seg_type tx_segment_first,
  input wire tsf_pkg::tsf_seg_type tx_segment_last,
  input wire tsf_pkg::tsf_seg_type tx_segment_abort,
  input wire logic tx_accept
);
  import tsf_pkg::*;
  // ==========================================================
  // Framing on the wire
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  abort_on_end_a: assert property (
    (tx_segment_abort & ~(tx_segment_last & tx_segment_valid)) == 4'h0)
    else $error("abort marker off an end transfer");
  valid_packed_a: assert property (
    tx_segment_valid inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
    else $error("valid segments not packed upward");
  stall_holds_a: assert property (
    !tx_accept |=> tx_segment_valid == 4'h0)
    else $error("transfer issued while not accepted");
  first_seg0_a: assert property (
    (tx_segment_first & tx_segment_valid & 4'hE) == 4'h0)
    else $error("first marker above segment zero");
  last_top_a: assert property (
    (|tx_segment_last) |->
      tx_segment_valid == tsf_seg_type'((tx_segment_last << 1) - 1))
    else $error("last marker not on top valid segment");
  first_once_a: assert property (
    (|tx_segment_first) |=> tx_segment_first == 4'h0)
    else $error("first marker on two beats in a row");
  idle_after_a: assert property (
    (|tx_segment_last) |=> tx_segment_valid == 4'h0)
    else $error("no idle cycle after an end beat");
  full_mid_a: assert property (
    (|tx_segment_valid) && !(|tx_segment_last) |->
      tx_segment_valid == 4'hF)
    else $error("middle beat not full");
endmodule
`default_nettype wire

// file: tb/testbench.sv
/*
  Bench joining both ends; a queue model predicts every MAC beat.
  Assumes the shared package and interface are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tsf_pkg::*;
  typedef struct {tsf_seg_type v, f, l, a; tsf_word_type w;
    tsf_empty_type e;} tsf_beat_type;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic armed = 1'b0;
  logic path_ready_i = 1'b1;
  logic send_i = 1'b0;
  logic [7:0] send_words_i = 8'h00;
  logic send_abort_i = 1'b0;
  tsf_word_type send_word_i = WORD_RST;
  tsf_empty_type send_empty_i = EMPTY_RST;
  logic busy_o, fcs_check_en_o, fcs_result_valid_o, framing_error_o;
  tsf_seg_type out_valid_o, out_first_o, out_last_o, out_aborted_o;
  tsf_word_type out_word_o [SEGS];
  tsf_empty_type out_empty_o [SEGS];
  logic [31:0] rnd = 32'h1fc9;
  int n_errors = 0;
  int n_checks = 0;
  int lens [5] = '{1, 3, 4, 5, 8};
  tsf_beat_type q [$];
  tsf_beat_type c;
  tsf_word_type xw;
  tsf_empty_type xe;
  // ==========================================================
  // Ends, wire and checker
  tsf_if tsf_if_i ();
  tsf_user_end tsf_user_end_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .send_i(send_i), .send_words_i(send_words_i),
    .send_abort_i(send_abort_i), .send_word_i(send_word_i),
    .send_empty_i(send_empty_i), .busy_o(busy_o), .bus(tsf_if_i.user));
  tsf_mac_end tsf_mac_end_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .bus(tsf_if_i.mac), .path_ready_i(path_ready_i),
    .out_valid_o(out_valid_o), .out_first_o(out_first_o),
    .out_last_o(out_last_o), .out_aborted_o(out_aborted_o),
    .out_word_o(out_word_o), .out_empty_o(out_empty_o),
    .fcs_check_en_o(fcs_check_en_o),
    .fcs_result_valid_o(fcs_result_valid_o),
    .framing_error_o(framing_error_o));
  tsf_frame_monitor tsf_frame_monitor_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .tx_segment_valid(tsf_if_i.tx_segment_valid),
    .tx_segment_first(tsf_if_i.tx_segment_first),
    .tx_segment_last(tsf_if_i.tx_segment_last),
    .tx_segment_abort(tsf_if_i.tx_segment_abort),
    .tx_accept(tsf_if_i.tx_accept));
  // ==========================================================
  // Clock, random stalls and helpers
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Random backpressure exercises the user end stopping mid-packet.
  always @(posedge mclk_i) begin
    rnd <= lfsr(rnd);
    path_ready_i <= rnd[2:0] != 3'h0;
    armed <= !rst_i;
  end
  task chk(input string n, input logic [127:0] s, input logic [127:0] x);
    n_checks++;
    if (s !== x) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, x, s);
    end
  endtask
  task send(input int len, input logic ab);
    tsf_beat_type b;
    int r;
    @(posedge mclk_i);
    send_i <= 1'b1;
    send_words_i <= 8'(len);
    send_abort_i <= ab;
    send_word_i <= {4{rnd}};
    send_empty_i <= rnd[7:4];
    for (int i = 0; i < (len + 3) / 4; i++) begin
      r = (len - 4 * i > 4) ? 4 : len - 4 * i;
      b.v = 4'((1 << r) - 1);
      b.f = (i == 0) ? 4'h1 : 4'h0;
      b.l = (len - 4 * i > 4) ? 4'h0 : 4'(1 << (r - 1));
      b.a = ab ? b.l : 4'h0;
      b.w = {4{rnd}};
      b.e = rnd[7:4];
      q.push_back(b);
    end
    @(posedge mclk_i);
    send_i <= 1'b0;
    #1;
    chk("busy", busy_o, 1);
    for (int i = 0; i < 400; i++) begin
      @(posedge mclk_i);
      #1;
      if (busy_o === 1'b0) break;
    end
    if (busy_o !== 1'b0) begin
      n_errors++;
      $display("packet never finished");
      results();
    end
  endtask
  // ==========================================================
  // Model comparison at every MAC beat
  always @(negedge mclk_i) begin
    if (armed && !rst_i) begin
      chk("framing", framing_error_o, 0);
      if (out_valid_o !== 4'h0 && q.size() == 0) begin
        chk("spare beat", 1, 0);
      end else if (out_valid_o !== 4'h0) begin
        c = q.pop_front();
        chk("valid", out_valid_o, c.v);
        chk("first", out_first_o, c.f);
        chk("last", out_last_o, c.l);
        chk("aborted", out_aborted_o, c.a);
        for (int s = 0; s < SEGS; s++) begin
          xw = c.a[s] ? ERR_WORD : c.w;
          xe = c.a[s] ? {c.e[EMPTY_W-1:EMPTY_LOW_W], EMPTY_LOW_ZERO} : c.e;
          chk("word", out_word_o[s], c.v[s] ? xw : WORD_RST);
          chk("empty", out_empty_o[s], c.l[s] ? xe : EMPTY_RST);
        end
        chk("fcs result", fcs_result_valid_o, |(c.l & ~c.a));
        chk("fcs enable", fcs_check_en_o, !(|c.a));
      end else begin
        chk("fcs enable", fcs_check_en_o, 1);
        chk("fcs result", fcs_result_valid_o, 0);
      end
    end
  end
  // ==========================================================
  // Tests and verdict
  task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // About 34 packets of at most 32 words; the limit leaves wide margin.
  initial begin
    #750000;
    n_errors++;
    $display("watchdog expired");
    results();
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) send(lens[i % 5], i > 4);
    $display("test directed done");
    for (int i = 0; i < 24; i++) send(int'(rnd[12:8]) + 1, rnd[13]);
    $display("test random done");
    repeat (4) @(posedge mclk_i);
    chk("beats left", q.size(), 0);
    results();
  end
endmodule
`default_nettype wire
